// ==== logic/fccrc_top.sv ====
// Purpose: Fast clock rate controller, two-phase movement pulse generator
// Assumes: Contacts and selector are asynchronous pins, contacts low when closed, selector high when on
// Notes:   Rates are held in quarter units; a step fires when the accumulator reaches the limit

`timescale 1ns/1ps
`default_nettype none

module fccrc_top #(
	parameter int CLK_HZ     = fccrc_pkg::CLK_HZ,
	parameter int PULSE_CYC  = fccrc_pkg::PULSE_CYC,
	parameter int DEB_CYC    = fccrc_pkg::DEB_CYC,
	parameter int STEP_LIMIT = fccrc_pkg::STEP_LIMIT,
	parameter int DIAL_STEPS = fccrc_pkg::DIAL_STEPS
) (
	// Clock and reset
	input  wire logic                           clk_in,
	input  wire logic                           rst_b_in,
	// Control contacts, low when closed
	input  wire logic                           stop_b_in,
	input  wire logic                           fast_forward_input_b_in,
	input  wire logic                           reset_run_b_in,
	// Speed selector, high when a switch is on
	input  wire logic [fccrc_pkg::SEL_WIDTH-1:0] speed_select_switches_in,
	// Movement drive and indicators
	output logic                                phase_a_out,
	output logic                                phase_b_out,
	output logic                                phase_a_indicator_out,
	output logic                                phase_b_indicator_out,
	// Status
	output logic                                running_out,
	output logic                                reset_run_out
);
	logic        rst_q1;
	logic        rst_q2;
	logic        rst_n;
	logic        stop_lvl;
	logic        ff_lvl;
	logic        rs_lvl;
	logic        stop_act;
	logic        ff_act;
	logic        rs_act;
	logic [4:0]  sel1_q;
	logic [4:0]  sel2_q;
	logic        reset_run_q;
	logic        run;
	logic [6:0]  rate;
	logic [31:0] acc_q;
	logic [32:0] acc_sum;
	logic        step;
	logic        phase_q;
	logic [31:0] pulse_cnt_q;
	logic        pulse_a_q;
	logic        pulse_b_q;
	logic [31:0] pos_q;
	logic [31:0] pos_nxt;
	logic        run_done;

	// Ratio in quarter units from the five live selector bits
	function automatic logic [6:0] sel_rate(input logic [4:0] s);
		logic [6:0] n7;
		logic [6:0] k7;
		n7 = {3'h0, s[3:0]};
		k7 = n7 - 7'h01;
		if (!s[fccrc_pkg::FRAC_BIT])
			sel_rate = (n7 + 7'h01) << 2;
		else if (s[3:0] == 4'h0)
			sel_rate = fccrc_pkg::FRAC_BASE_Q;
		else
			sel_rate = fccrc_pkg::FRAC_STEP_Q + ((k7 / 7'h03) << 2) + (k7 % 7'h03);
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rst_q1 <= 1'b0;
			rst_q2 <= 1'b0;
		end
		else
		begin
			rst_q1 <= 1'b1;
			rst_q2 <= rst_q1;
		end
	end
	assign rst_n = rst_q2;

	// Contact conditioning
	fccrc_debounce #(.STABLE_CYC(DEB_CYC)) u_stop (
		.clk_in    (clk_in),
		.rst_b_in  (rst_n),
		.raw_in    (stop_b_in),
		.level_out (stop_lvl)
	);
	fccrc_debounce #(.STABLE_CYC(DEB_CYC)) u_ff (
		.clk_in    (clk_in),
		.rst_b_in  (rst_n),
		.raw_in    (fast_forward_input_b_in),
		.level_out (ff_lvl)
	);
	fccrc_debounce #(.STABLE_CYC(DEB_CYC)) u_rs (
		.clk_in    (clk_in),
		.rst_b_in  (rst_n),
		.raw_in    (reset_run_b_in),
		.level_out (rs_lvl)
	);
	assign stop_act = !stop_lvl;
	assign ff_act   = !ff_lvl;
	assign rs_act   = !rs_lvl;

	// Selector synchroniser, sixth bit dropped
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel1_q <= 5'h00;
			sel2_q <= 5'h00;
		end
		else
		begin
			sel1_q <= speed_select_switches_in[4:0];
			sel2_q <= sel1_q;
		end
	end

	// Run and rate choice
	assign run  = reset_run_q || !stop_act;
	assign rate = (reset_run_q || ff_act) ? fccrc_pkg::FF_RATE_Q : sel_rate(sel2_q);

	// Step accumulator
	assign acc_sum = {1'b0, acc_q} + {26'h0, rate};
	assign step    = run && (acc_sum >= 33'(STEP_LIMIT));
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			acc_q <= 32'h0;
		else if (step)
			acc_q <= 32'(acc_sum - 33'(STEP_LIMIT));
		else if (run)
			acc_q <= acc_sum[31:0];
	end

	// Dial position since power-up
	assign pos_nxt  = (pos_q >= 32'(DIAL_STEPS - 1)) ? 32'h0 : pos_q + 32'h1;
	assign run_done = step && (pos_nxt == 32'h0);
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			pos_q <= 32'h0;
		else if (step)
			pos_q <= pos_nxt;
	end

	// Latched reset run
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			reset_run_q <= 1'b0;
		else if (reset_run_q && run_done)
			reset_run_q <= 1'b0;
		else if (!reset_run_q && rs_act && stop_act && pos_q != 32'h0)
			reset_run_q <= 1'b1;
	end

	// Alternating drive pulses
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_q     <= 1'b0;
			pulse_cnt_q <= 32'h0;
			pulse_a_q   <= 1'b0;
			pulse_b_q   <= 1'b0;
		end
		else if (step)
		begin
			phase_q     <= !phase_q;
			pulse_cnt_q <= 32'(PULSE_CYC - 1);
			pulse_a_q   <= !phase_q;
			pulse_b_q   <= phase_q;
		end
		else if (pulse_cnt_q != 32'h0)
			pulse_cnt_q <= pulse_cnt_q - 32'h1;
		else
		begin
			pulse_a_q <= 1'b0;
			pulse_b_q <= 1'b0;
		end
	end

	assign phase_a_out           = pulse_a_q;
	assign phase_b_out           = pulse_b_q;
	assign phase_a_indicator_out = pulse_a_q;
	assign phase_b_indicator_out = pulse_b_q;
	assign running_out           = run;
	assign reset_run_out         = reset_run_q;

	// Checks
	stop_halts_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(stop_act && !reset_run_q) |=> !$rose(pulse_a_q) && !$rose(pulse_b_q))
		else $error("step while stopped");
	ff_rate_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		ff_act |-> rate == fccrc_pkg::FF_RATE_Q)
		else $error("fast-forward rate wrong");
	ff_release_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		($fell(ff_act) && !reset_run_q && !stop_act) |-> run && rate == sel_rate(sel2_q))
		else $error("fast-forward release wrong");
	latch_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(reset_run_q && !run_done) |=> reset_run_q)
		else $error("reset run dropped early");
	accept_stopped_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		$rose(reset_run_q) |-> $past(stop_act) && $past(rs_act) && run)
		else $error("reset run started while running");
	end_home_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		$fell(reset_run_q) |-> pos_q == 32'h0)
		else $error("reset run ended away from home");
	open_runs_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(!stop_act && !ff_act && !reset_run_q) |-> run && rate == sel_rate(sel2_q))
		else $error("not running at selected rate");
	bit_six_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		$changed(speed_select_switches_in[5]) && $stable(speed_select_switches_in[4:0]) ##2 1 |-> $stable(sel2_q))
		else $error("sixth bit affects rate");
	frac_range_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(sel2_q[4] && !ff_act && !reset_run_q) |-> rate >= fccrc_pkg::FRAC_BASE_Q && rate <= 7'h1f && rate[1:0] != 2'h0)
		else $error("fractional rate out of range");
	sel_apply_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(!ff_act && !reset_run_q && !$stable(sel2_q)) |-> rate == sel_rate(sel2_q))
		else $error("new ratio not applied");
	alternate_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		step |=> (pulse_a_q != pulse_b_q) && phase_q != $past(phase_q))
		else $error("phases not alternating");
	no_overlap_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		!(pulse_a_q && pulse_b_q))
		else $error("both phases active");
	ff_ignored_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		reset_run_q |-> rate == fccrc_pkg::FF_RATE_Q && run)
		else $error("reset run rate wrong");
	dial_wrap_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(step && pos_q == 32'(DIAL_STEPS - 1)) |=> pos_q == 32'h0)
		else $error("dial count did not wrap");

	reset_end_c: cover property (@(posedge clk_in) disable iff (!rst_n) $fell(reset_run_q));
	ff_step_c: cover property (@(posedge clk_in) disable iff (!rst_n) ff_act && step);
	frac_step_c: cover property (@(posedge clk_in) disable iff (!rst_n) sel2_q[4] && step);
endmodule // fccrc_top

`default_nettype wire

// ==== logic/fccrc_pkg.sv ====
// Purpose: Constants and contact debouncer for the fast clock rate controller
// Assumes: 100 MHz clk_in, contacts pull low to common when closed
// Notes:   Times are given in their own units, cycle counts derived here

`timescale 1ns/1ps
`default_nettype none

package fccrc_pkg;
	localparam int        CLK_HZ      = 100000000;
	localparam int        STEP_HZ     = 2;
	localparam int        QUARTERS    = 4;
	localparam int        PULSE_MS    = 10;
	localparam int        DEB_MS      = 10;
	localparam int        PULSE_CYC   = CLK_HZ / 1000 * PULSE_MS;
	localparam int        DEB_CYC     = CLK_HZ / 1000 * DEB_MS;
	localparam int        STEP_LIMIT  = CLK_HZ / STEP_HZ * QUARTERS;
	localparam int        DIAL_STEPS  = 12 * 3600 * STEP_HZ;
	localparam logic [6:0] FF_RATE_Q  = 7'h44;
	localparam logic [6:0] FRAC_BASE_Q = 7'h0a;
	localparam logic [6:0] FRAC_STEP_Q = 7'h0d;
	localparam int        SEL_WIDTH   = 6;
	localparam int        FRAC_BIT    = 4;
endpackage

module fccrc_debounce #(
	parameter int STABLE_CYC = fccrc_pkg::DEB_CYC
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	// Contact
	input  wire logic raw_in,
	output logic      level_out
);
	logic        sync1_q;
	logic        sync2_q;
	logic        level_q;
	logic [31:0] cnt_q;

	// Two-stage synchroniser
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end
		else
		begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	// Level accepted after a stable run
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			cnt_q   <= 32'h0;
			level_q <= 1'b1;
		end
		else if (sync2_q == level_q)
			cnt_q <= 32'h0;
		else if (cnt_q >= 32'(STABLE_CYC - 1))
		begin
			cnt_q   <= 32'h0;
			level_q <= sync2_q;
		end
		else
			cnt_q <= cnt_q + 32'h1;
	end

	assign level_out = level_q;
endmodule // fccrc_debounce

`default_nettype wire

// ==== bench/fccrc_movement.sv ====
// Purpose: Movement model counting steps and checking phase order
// Assumes: Phase pulses are active high, first step is phase A
// Notes:   Position wraps at one dial turn of DIAL steps

`timescale 1ns/1ps
`default_nettype none

module fccrc_movement #(
	parameter int DIAL = 8
) (
	// Clock and drive
	input  wire logic        clk_in,
	input  wire logic        phase_a_in,
	input  wire logic        phase_b_in,
	// Counts
	output logic [31:0]      steps_out,
	output logic [31:0]      pos_out,
	output logic [31:0]      alt_err_out
);
	logic a_q = 1'b0;
	logic b_q = 1'b0;
	logic last_q = 1'b1;

	initial
	begin
		steps_out = 32'h0;
		pos_out = 32'h0;
		alt_err_out = 32'h0;
	end

	// Count each new pulse and flag repeats of one phase
	always @(posedge clk_in)
	begin
		a_q <= phase_a_in;
		b_q <= phase_b_in;
		if ((phase_a_in && !a_q) || (phase_b_in && !b_q))
		begin
			steps_out <= steps_out + 32'h1;
			pos_out <= (pos_out + 32'h1) % DIAL;
			last_q <= phase_b_in;
			if (phase_b_in == last_q || (phase_a_in && phase_b_in))
				alt_err_out <= alt_err_out + 32'h1;
		end
	end
endmodule // fccrc_movement

`default_nettype wire

// ==== bench/fast_clock_rate_controller_test.sv ====
// Purpose: Self-checking bench for the rate controller
// Assumes: Short counts set through top parameters
// Notes:   Step counts are allowed one step of phase slack

`timescale 1ns/1ps
`default_nettype none

module fast_clock_rate_controller_test;
	localparam int SET = 10;
	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic        stop_b = 1'b1;
	logic        ff_b = 1'b1;
	logic        rr_b = 1'b1;
	logic [5:0]  sel = 6'h00;
	logic        pa, pb, run, rr;
	logic [31:0] steps, pos, alt_err;
	logic        ia, ib;
	logic [31:0] led_steps, led_pos, led_alt;
	int          mismatches = 0;
	int          compares = 0;

	always #5 clk_in = ~clk_in;

	fccrc_top #(.PULSE_CYC(4), .DEB_CYC(3), .STEP_LIMIT(400), .DIAL_STEPS(8)) fccrc_top_i (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .stop_b_in(stop_b),
		.fast_forward_input_b_in(ff_b), .reset_run_b_in(rr_b), .speed_select_switches_in(sel),
		.phase_a_out(pa), .phase_b_out(pb), .phase_a_indicator_out(ia), .phase_b_indicator_out(ib),
		.running_out(run), .reset_run_out(rr));

	fccrc_movement #(.DIAL(8)) fccrc_movement_i (
		.clk_in(clk_in), .phase_a_in(pa), .phase_b_in(pb),
		.steps_out(steps), .pos_out(pos), .alt_err_out(alt_err));

	fccrc_movement #(.DIAL(8)) fccrc_movement_led_i (
		.clk_in(clk_in), .phase_a_in(ia), .phase_b_in(ib),
		.steps_out(led_steps), .pos_out(led_pos), .alt_err_out(led_alt));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic rate(input int win, input int exp);
		logic [31:0] s0;
		logic [31:0] s1;
		int          d;
		int          e;
		s0 = steps;
		s1 = led_steps;
		cyc(win);
		d = int'(steps - s0) - exp;
		e = int'(led_steps - s1) - exp;
		check({31'h0, d >= -1 && d <= 1}, 32'h1);
		check({31'h0, e >= -1 && e <= 1}, 32'h1);
	endtask

	// Ratio in quarter units for selector code i
	function automatic int q(input int i);
		if (i < 16)
			return (i + 1) * 4;
		if (i == 16)
			return 10;
		return 12 + (i - 16) + (i - 17) / 3;
	endfunction

	task automatic final_report;
		if (mismatches == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		cyc(3);
		rst_b_in <= 1'b1;
		cyc(SET);
		for (int i = 0; i < 32; i++)
		begin
			sel <= 6'(i) | (i[0] ? 6'h20 : 6'h00);
			cyc(3);
			sel <= sel ^ 6'h20;
			cyc(3);
			rate(1600, 4 * q(i));
		end
		sel <= 6'h05;
		ff_b <= 1'b0;
		cyc(SET);
		rate(800, 136);
		stop_b <= 1'b0;
		cyc(SET);
		rate(400, 0);
		check({31'h0, run}, 32'h0);
		stop_b <= 1'b1;
		cyc(SET);
		ff_b <= 1'b1;
		cyc(SET);
		rate(800, 48);
		rr_b <= 1'b0;
		cyc(SET);
		rr_b <= 1'b1;
		check({31'h0, rr}, 32'h0);
		while (pos !== 32'h1)
			cyc(1);
		stop_b <= 1'b0;
		cyc(SET);
		rr_b <= 1'b0;
		cyc(SET);
		rr_b <= 1'b1;
		cyc(SET);
		check({31'h0, rr}, 32'h1);
		for (int k = 0; k < 300 && rr === 1'b1; k++)
			cyc(1);
		cyc(3);
		check(pos, 32'h0);
		rate(400, 0);
		check(alt_err, 32'h0);
		check(led_alt, 32'h0);
		check(led_pos, 32'h0);
		final_report;
	end

	initial
	begin
		cyc(90000);
		mismatches++;
		final_report;
	end
endmodule // fast_clock_rate_controller_test

`default_nettype wire
